// >>> rtl/ssp_link.sv
// Purpose: i2c slave engine on sampled scl and sda
// Assumes: scl much slower than clk_in
// Notes:   pins pass two flops before any use
`timescale 1ns/10ps
module ssp_link (
    input  wire logic clk_in,
    input  wire logic rst_in,
    input  wire logic scl_in,
    input  wire logic sda_in,
    output logic      sda_out,
    output logic      sda_oe_out,
    ssp_link_if.lnk   lk
);
    ssp_pkg::ssp_lnk_t r;
    ssp_pkg::ssp_lnk_t n;
    logic scl;
    logic sda;
    logic rise;
    logic fall;
    // edge and condition detection on the second sync stage
    assign scl  = r.scl_s[1];
    assign sda  = r.sda_s[1];
    assign rise = scl & ~r.scl_d;
    assign fall = ~scl & r.scl_d;
    // next state of the engine
    always_comb begin
        n = r;
        n.scl_s = {r.scl_s[0], scl_in};
        n.sda_s = {r.sda_s[0], sda_in};
        n.scl_d = scl;
        n.sda_d = sda;
        n.start = 1'b0;
        n.stop = 1'b0;
        n.amatch = 1'b0;
        n.rxdone = 1'b0;
        n.txdone = 1'b0;
        n.nack = 1'b0;
        if (!lk.en) begin
            n.st = ssp_pkg::SSP_IDLE;
            n.drv = 1'b0;
        end else if (scl && r.scl_d && !sda && r.sda_d) begin
            n.start = 1'b1;
            n.st = ssp_pkg::SSP_ADDR;
            n.cnt = 4'h0;
            n.drv = 1'b0;
        end else if (scl && r.scl_d && sda && !r.sda_d) begin
            n.stop = 1'b1;
            n.st = ssp_pkg::SSP_IDLE;
            n.drv = 1'b0;
        end else if (r.st != ssp_pkg::SSP_IDLE && r.st != ssp_pkg::SSP_SKIP) begin
            if (rise) begin
                n.cnt = r.cnt + 4'h1;
                if (r.cnt < 4'h8 && r.st != ssp_pkg::SSP_TX) begin
                    n.sh = {r.sh[6:0], sda};
                end
                if (r.cnt == 4'h8 && r.st == ssp_pkg::SSP_TX) begin
                    n.nack = sda;
                    n.txdone = ~sda;
                    if (sda) begin
                        n.st = ssp_pkg::SSP_SKIP;
                    end
                end
            end else if (fall) begin
                if (r.cnt == 4'h8) begin
                    n.drv = r.st != ssp_pkg::SSP_TX;
                    if (r.st == ssp_pkg::SSP_ADDR) begin
                        n.amatch = r.sh[7:1] == lk.own_addr;
                        n.rw = r.sh[0];
                        n.drv = r.sh[7:1] == lk.own_addr;
                        if (r.sh[7:1] != lk.own_addr) begin
                            n.st = ssp_pkg::SSP_SKIP;
                        end
                    end
                    n.rxdone = r.st == ssp_pkg::SSP_RX;
                end else if (r.cnt == 4'h9) begin
                    n.cnt = 4'h0;
                    n.drv = 1'b0;
                    if (r.st == ssp_pkg::SSP_ADDR) begin
                        n.st = r.rw ? ssp_pkg::SSP_TX : ssp_pkg::SSP_RX;
                    end
                    if (n.st == ssp_pkg::SSP_TX) begin
                        n.sh = lk.tx_data;
                        n.drv = ~lk.tx_data[7];
                    end
                end else if (r.st == ssp_pkg::SSP_TX) begin
                    n.drv = ~r.sh[3'd7 - r.cnt[2:0]];
                end
            end
        end
    end
    // state register
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            r <= '0;
            r.scl_s <= 2'h3;
            r.sda_s <= 2'h3;
            r.scl_d <= 1'b1;
            r.sda_d <= 1'b1;
        end else begin
            r <= n;
        end
    end
    // open-drain pin: drives low only
    assign sda_out = 1'b0;
    assign sda_oe_out = r.drv;
    assign lk.start = r.start;
    assign lk.stop = r.stop;
    assign lk.amatch = r.amatch;
    assign lk.rw = r.rw;
    assign lk.rxdone = r.rxdone;
    assign lk.rxbyte = r.sh;
    assign lk.txdone = r.txdone;
    assign lk.nack = r.nack;
    assign lk.busy = r.st == ssp_pkg::SSP_TX;
endmodule

// >>> rtl/ssp_link_if.sv
// Purpose: carrier between register side and link engine
// Assumes: one clock for both ends
// Notes:   events are one-cycle pulses
`timescale 1ns/10ps
interface ssp_link_if;
    logic       en;
    logic [6:0] own_addr;
    logic [7:0] tx_data;
    logic       start;
    logic       stop;
    logic       amatch;
    logic       rw;
    logic       rxdone;
    logic [7:0] rxbyte;
    logic       txdone;
    logic       nack;
    logic       busy;
    modport ctl (output en, own_addr, tx_data,
                 input start, stop, amatch, rw, rxdone, rxbyte, txdone, nack, busy);
    modport lnk (input en, own_addr, tx_data,
                 output start, stop, amatch, rw, rxdone, rxbyte, txdone, nack, busy);
endinterface

// >>> rtl/ssp_params.svh
// Purpose: constants of the serial port status and control block
// Assumes: apb byte addresses, 8-bit registers in the low lane
// Notes:   included by its bare name
`ifndef SSP_PARAMS_SVH
`define SSP_PARAMS_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define SSP_CTRL_OFF 12'h014
`define SSP_STAT_OFF 12'h094
`define SSP_BUF_OFF  12'h020
`define SSP_ADDR_OFF 12'h024
`define SSP_IST_OFF  12'h028
`define SSP_IMSK_OFF 12'h02c
// ----------------------------------------
// field positions
// ----------------------------------------
`define SSP_C_WRITE_COLLISION_FLAG 7
`define SSP_C_OVF  6
`define SSP_C_EN   5
`define SSP_C_CKP  4
`define SSP_S_DA   5
`define SSP_S_STOP 4
`define SSP_S_STRT 3
`define SSP_S_RW   2
`define SSP_S_UA   1
`define SSP_S_BF   0
`define SSP_I_BYTE 0
`define SSP_I_STRT 1
`define SSP_I_STOP 2
// ----------------------------------------
// reset values
// ----------------------------------------
`define SSP_CTRL_RST 8'h00
`define SSP_STAT_RST 8'h00
`define SSP_ADDR_RST 8'h00
`define SSP_IRQ_RST  3'h0
`endif

// >>> rtl/ssp_pkg.sv
// Purpose: types of the serial port block
// Assumes: nothing
// Notes:   state struct of the link engine only
package ssp_pkg;
    // port mode codes
    typedef enum logic [3:0] {
        SSP_MODE_I2C7 = 4'h6
    } ssp_mode_t;
    // link engine states
    typedef enum logic [2:0] {
        SSP_IDLE = 3'b000,
        SSP_ADDR = 3'b001,
        SSP_RX   = 3'b010,
        SSP_TX   = 3'b011,
        SSP_SKIP = 3'b100
    } ssp_lst_t;
    // link engine state
    typedef struct packed {
        logic [1:0] scl_s;
        logic [1:0] sda_s;
        logic       scl_d;
        logic       sda_d;
        ssp_lst_t   st;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic       drv;
        logic       rw;
        logic       start;
        logic       stop;
        logic       amatch;
        logic       rxdone;
        logic       txdone;
        logic       nack;
    } ssp_lnk_t;
endpackage

// >>> rtl/ssp_top.sv
// Purpose: apb register file of the serial port with i2c slave link
// Assumes: apb master per protocol, i2c link slower than clk_in
// Notes:   only the 7-bit slave mode moves data
//
// The implementer's own choice: register access over APB.
`timescale 1ns/10ps
`include "ssp_params.svh"
module ssp_top (
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [11:0] paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe_out,
    output logic             irq_out
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic [7:0]  ctrl;
        logic [1:0]  cfg;
        logic        da;
        logic        stop;
        logic        start;
        logic        rw;
        logic        bf;
        logic [7:0]  rxbuf;
        logic [7:0]  txbuf;
        logic [7:0]  addr;
        logic [2:0]  ist;
        logic [2:0]  imsk;
        logic        irq;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } ssp_top_st_t;

    ssp_top_st_t r;
    ssp_top_st_t n;
    ssp_link_if  lk ();
    logic        acc;
    logic        wr;
    logic        rd;
    logic        en;
    logic        i2c;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // decodes an offset to a mapped register
    function automatic logic is_mapped(input logic [11:0] a);
        is_mapped = a == `SSP_CTRL_OFF || a == `SSP_STAT_OFF ||
                    a == `SSP_BUF_OFF  || a == `SSP_ADDR_OFF ||
                    a == `SSP_IST_OFF  || a == `SSP_IMSK_OFF;
    endfunction

    // zero-extends a byte onto the data bus
    function automatic logic [31:0] ext8(input logic [7:0] v);
        ext8 = {24'h000000, v};
    endfunction

    // assembles the status byte
    function automatic logic [7:0] stat_byte(input ssp_top_st_t s);
        stat_byte = {s.cfg, s.da, s.stop, s.start, s.rw, 1'b0, s.bf};
    endfunction

    // ----------------------------------------
    // bus qualifiers
    // ----------------------------------------
    // the access completes on the edge where pready is high
    assign acc = psel_in & penable_in & r.pready;
    assign wr  = acc & pwrite_in & is_mapped(paddr_in);
    assign rd  = acc & ~pwrite_in;
    assign en  = r.ctrl[`SSP_C_EN];
    assign i2c = r.ctrl[3:0] == ssp_pkg::SSP_MODE_I2C7;

    // ----------------------------------------
    // link side
    // ----------------------------------------
    // controls handed to the engine
    assign lk.en       = en & i2c;
    assign lk.own_addr = r.addr[7:1];
    assign lk.tx_data  = r.txbuf;

    // i2c slave engine
    ssp_link u_link (
        .clk_in     (clk_in),
        .rst_in     (rst_in),
        .scl_in     (scl_in),
        .sda_in     (sda_in),
        .sda_out    (sda_out),
        .sda_oe_out (sda_oe_out),
        .lk         (lk)
    );

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        n = r;
        n.pslverr = 1'b0;

        // apb answer: one wait state, then pready for one cycle
        n.pready = psel_in & penable_in & ~r.pready;
        if (psel_in && penable_in && !r.pready) begin
            n.pslverr = ~is_mapped(paddr_in);
            n.prdata = 32'h00000000;
            if (!pwrite_in) begin
                unique case (paddr_in)
                    `SSP_CTRL_OFF: n.prdata = ext8(r.ctrl);
                    `SSP_STAT_OFF: n.prdata = ext8(stat_byte(r));
                    `SSP_BUF_OFF:  n.prdata = ext8(r.rxbuf);
                    `SSP_ADDR_OFF: n.prdata = ext8(r.addr);
                    `SSP_IST_OFF:  n.prdata = {29'h00000000, r.ist};
                    `SSP_IMSK_OFF: n.prdata = {29'h00000000, r.imsk};
                    default:       n.prdata = 32'h00000000;
                endcase
            end
        end

        // software writes
        if (wr) begin
            unique case (paddr_in)
                `SSP_CTRL_OFF: n.ctrl = pwdata_in[7:0];
                `SSP_STAT_OFF: n.cfg = pwdata_in[7:6];
                `SSP_ADDR_OFF: n.addr = pwdata_in[7:0];
                `SSP_IMSK_OFF: n.imsk = pwdata_in[2:0];
                `SSP_IST_OFF:  n.ist = r.ist & ~pwdata_in[2:0];
                default:       n.txbuf = r.txbuf;
            endcase
        end

        // buffer write: collision while shifting out
        if (wr && paddr_in == `SSP_BUF_OFF) begin
            if (lk.busy) begin
                n.ctrl[`SSP_C_WRITE_COLLISION_FLAG] = 1'b1;
            end else begin
                n.txbuf = pwdata_in[7:0];
            end
        end

        // buffer read empties it
        if (rd && paddr_in == `SSP_BUF_OFF) begin
            n.bf = 1'b0;
        end

        // start and stop tracking
        if (!en) begin
            n.start = 1'b0;
            n.stop = 1'b0;
        end else if (lk.start) begin
            n.start = 1'b1;
            n.stop = 1'b0;
        end else if (lk.stop) begin
            n.stop = 1'b1;
            n.start = 1'b0;
        end

        // direction bit window
        if (lk.amatch) begin
            n.rw = lk.rw;
            n.da = 1'b0;
        end else if (lk.start || lk.stop || lk.nack || !en) begin
            n.rw = 1'b0;
        end

        // received byte lands unless the buffer still holds one
        if (lk.rxdone) begin
            n.da = 1'b1;
            if (r.bf && !(rd && paddr_in == `SSP_BUF_OFF)) begin
                n.ctrl[`SSP_C_OVF] = 1'b1;
            end else begin
                n.rxbuf = lk.rxbyte;
                n.bf = 1'b1;
            end
        end
        // a byte sent out is data whether the master acked or not
        if (lk.txdone || lk.nack) begin
            n.da = 1'b1;
        end

        // sticky interrupt events win over a clear
        if (lk.rxdone || lk.amatch || lk.txdone) begin
            n.ist[`SSP_I_BYTE] = 1'b1;
        end
        if (lk.start) begin
            n.ist[`SSP_I_STRT] = 1'b1;
        end
        if (lk.stop) begin
            n.ist[`SSP_I_STOP] = 1'b1;
        end
        n.irq = |(n.ist & n.imsk);
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            r <= '0;
            r.ctrl <= `SSP_CTRL_RST;
            r.addr <= `SSP_ADDR_RST;
            r.ist <= `SSP_IRQ_RST;
            r.imsk <= `SSP_IRQ_RST;
        end else begin
            r <= n;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign prdata_out  = r.prdata;
    assign pready_out  = r.pready;
    assign pslverr_out = r.pslverr;
    assign irq_out     = r.irq;
endmodule

// >>> verification/ssp_chk.sv
// Purpose: port checks of the serial port top
// Assumes: one clock domain, sync reset
// Notes:   bound to every ssp_top
`timescale 1ns/10ps
module ssp_chk (
    input wire logic        clk_in,
    input wire logic        rst_in,
    input wire logic        psel_in,
    input wire logic        penable_in,
    input wire logic        pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] prdata_out,
    input wire logic        pready_out,
    input wire logic        pslverr_out,
    input wire logic        scl_in,
    input wire logic        sda_out,
    input wire logic        sda_oe_out,
    input wire logic        irq_out
);
    logic map_ok;
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);
    // address hits one of the six registers
    assign map_ok = paddr_in inside {12'h014, 12'h094, 12'h020, 12'h024, 12'h028, 12'h02c};
    a_access_wait: assert property (psel_in && !penable_in |-> ##2 pready_out)
        else $error("answer not two edges after setup");
    a_ready_pulse: assert property (pready_out |=> !pready_out)
        else $error("ready longer than one cycle");
    a_ready_cause: assert property (pready_out |->
        psel_in && penable_in && $past(psel_in, 2) && !$past(penable_in, 2))
        else $error("ready without a transfer");
    a_err_decode: assert property (pready_out |-> pslverr_out == !map_ok)
        else $error("error flag does not match decode");
    a_err_only_ready: assert property (pslverr_out |-> pready_out)
        else $error("error flag outside answer");
    a_read_lane: assert property (pready_out && !pwrite_in |->
        prdata_out[31:8] == 24'h0 && (map_ok || prdata_out == 32'h0))
        else $error("read data outside low lane");
    a_sda_open: assert property (sda_out == 1'b0)
        else $error("data pin driven high");
    a_ack_scl_low: assert property ($rose(sda_oe_out) |-> !scl_in)
        else $error("data pin taken while clock high");
    a_reset_quiet: assert property ($fell(rst_in) |-> !pready_out && !irq_out && !sda_oe_out)
        else $error("outputs active after reset");
endmodule
bind ssp_top ssp_chk i_chk (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .scl_in(scl_in), .sda_out(sda_out), .sda_oe_out(sda_oe_out), .irq_out(irq_out));

// >>> verification/ssp_i2c_mst.sv
// Purpose: i2c master model facing the slave port
// Assumes: 160 ns bit period, pulled-up wires
// Notes:   scl stands high between frames
`timescale 1ns/10ps
module ssp_i2c_mst (
    input  wire logic clk_in,
    output logic      scl_out,
    output logic      sda_out,
    input  wire logic sda_in
);
    // both wires released at start
    initial begin
        scl_out = 1'b1;
        sda_out = 1'b1;
    end
    // odd offset after a clock edge keeps every pin change off the edges
    task automatic align;
        @(posedge clk_in);
        #7;
    endtask
    // start or repeated start
    task automatic start;
        align;
        sda_out = 1'b1;
        #40 scl_out = 1'b1;
        #40 sda_out = 1'b0;
        #40 scl_out = 1'b0;
    endtask
    // one bit: data moves mid low phase, sampled mid high phase
    task automatic clk_bit(input logic b, output logic s);
        #40 sda_out = b;
        #40 scl_out = 1'b1;
        #40 s = sda_in;
        #40 scl_out = 1'b0;
    endtask
    // byte out msb first, then ack sampled
    task automatic wbyte(input logic [7:0] v, output logic ack);
        logic s;
        align;
        for (int i = 7; i >= 0; i--) clk_bit(v[i], s);
        clk_bit(1'b1, ack);
    endtask
    // byte in msb first, then ack or nack sent
    task automatic rbyte(input logic nack, output logic [7:0] v);
        logic s;
        align;
        for (int i = 7; i >= 0; i--) clk_bit(1'b1, v[i]);
        clk_bit(nack, s);
    endtask
    // stop condition
    task automatic stop;
        align;
        #40 sda_out = 1'b0;
        #40 scl_out = 1'b1;
        #40 sda_out = 1'b1;
        #40;
    endtask
endmodule

// >>> verification/tb.sv
// Purpose: self-checking bench of the serial port block
// Assumes: one wait state apb, i2c master model
// Notes:   seeded random address and data
`timescale 1ns/10ps
module tb;
    logic        clk_in = 0;
    logic        rst_in = 1;
    logic        psel, pen, pwr, pready, perr, er, ack;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic        scl, m_sda, sda_o, sda_oe, irq;
    logic [7:0]  d, t;
    logic [6:0]  adr;
    int          seed = 32'hc4e9;
    int          mismatches = 0;
    int          n_checks = 0;
    wire logic   sda = m_sda & ~sda_oe; // pulled-up open-drain wire
    always #10 clk_in = ~clk_in;
    ssp_top i_dut (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel), .penable_in(pen),
        .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(perr), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_o), .sda_oe_out(sda_oe), .irq_out(irq));
    ssp_i2c_mst i_mst (.clk_in(clk_in), .scl_out(scl), .sda_out(m_sda), .sda_in(sda));
    // verdict and end of run
    task test_done;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // compare seen against expected
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    // one apb transfer, waits for ready under a bound
    task apb(input logic w, input logic [11:0] a, input logic [31:0] v);
        int n;
        @(posedge clk_in);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= v;
        @(posedge clk_in);
        pen <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            mismatches++;
            test_done;
        end
        q = prdata;
        er = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task rd(input logic [11:0] a);
        apb(1'b0, a, 32'h0);
    endtask
    // expected status word
    function logic [31:0] st(input logic da, p, s, rw, bf);
        return {26'h0, da, p, s, rw, 1'b0, bf};
    endfunction
    // main sequence
    initial begin
        psel = 0;
        pen = 0;
        pwr = 0;
        paddr = 0;
        pwdata = 0;
        repeat (12) @(posedge clk_in);
        rst_in <= 1'b0;
        rd(12'h014);
        chk(q, 32'h0);
        rd(12'h094);
        chk(q, 32'h0);
        rd(12'h0f0);
        chk(er, 1'b1);
        chk(q, 32'h0);
        apb(1'b1, 12'h014, 32'h26);
        rd(12'h014);
        chk(q, 32'h26);
        apb(1'b1, 12'h094, 32'hff);
        rd(12'h094);
        chk(q, 32'hc0);
        apb(1'b1, 12'h094, 32'h0);
        adr = 7'($random(seed));
        apb(1'b1, 12'h024, {adr, 1'b0});
        apb(1'b1, 12'h02c, 32'h7);
        i_mst.start;
        rd(12'h094);
        chk(q, st(0, 0, 1, 0, 0));
        chk(irq, 1'b1);
        rd(12'h028);
        chk(q, 32'h2);
        apb(1'b1, 12'h028, 32'h2);
        i_mst.wbyte({adr, 1'b0}, ack);
        chk(ack, 1'b0);
        rd(12'h094);
        chk(q, st(0, 0, 1, 0, 0));
        for (int k = 0; k < 4; k++) begin
            d = 8'($random(seed));
            i_mst.wbyte(d, ack);
            chk(ack, 1'b0);
            rd(12'h094);
            chk(q, st(1, 0, 1, 0, 1));
            rd(12'h020);
            chk(q, d);
            rd(12'h094);
            chk(q, st(1, 0, 1, 0, 0));
        end
        // second byte while the buffer is full: kept out, overflow set, still acked
        d = 8'($random(seed));
        i_mst.wbyte(d, ack);
        chk(ack, 1'b0);
        i_mst.wbyte(~d, ack);
        chk(ack, 1'b0);
        rd(12'h014);
        chk(q, 32'h66);
        rd(12'h020);
        chk(q, d);
        apb(1'b1, 12'h014, 32'h26);
        i_mst.stop;
        rd(12'h094);
        chk(q, st(1, 1, 0, 0, 0));
        t = 8'($random(seed));
        apb(1'b1, 12'h020, t);
        i_mst.start;
        i_mst.wbyte({adr, 1'b1}, ack);
        chk(ack, 1'b0);
        rd(12'h094);
        chk(q & 32'hfe, st(0, 0, 1, 1, 0));
        // buffer write while shifting out: ignored, collision set
        apb(1'b1, 12'h020, ~t);
        rd(12'h014);
        chk(q, 32'ha6);
        apb(1'b1, 12'h014, 32'h26);
        i_mst.rbyte(1'b1, d);
        chk(d, t);
        rd(12'h094);
        chk(q & 32'hfe, st(1, 0, 1, 0, 0));
        i_mst.start;
        i_mst.wbyte({adr ^ 7'h01, 1'b0}, ack);
        chk(ack, 1'b1);
        i_mst.stop;
        rd(12'h028);
        chk(q, 32'h7);
        apb(1'b1, 12'h02c, 32'h0);
        rd(12'h028);
        chk(irq, 1'b0);
        apb(1'b1, 12'h028, 32'h7);
        apb(1'b1, 12'h02c, 32'h7);
        rd(12'h028);
        chk(q, 32'h0);
        chk(irq, 1'b0);
        i_mst.start;
        apb(1'b1, 12'h014, 32'h06);
        rd(12'h094);
        chk(q & 32'h18, 32'h0);
        i_mst.stop;
        test_done;
    end
endmodule
